// >>> src/timer_params.svh
// register offsets, field positions, reset values and timing counts for the timer
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets (byte index on the plain register port)
// ----------------------------------------------------------------------
`define REG_CTRL_A      4'h0
`define REG_CTRL_B      4'h1
`define REG_CNT_LO      4'h2
`define REG_CNT_HI      4'h3
`define REG_CMP_A       4'h4
`define REG_CMP_B       4'h5
`define REG_FLAGS       4'h6
`define REG_IRQ_EN      4'h7

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CA_WAVE_BIT     0
`define CA_EDGE_BIT     3
`define CA_ACIC_BIT     4
`define CA_CAPEN_BIT    6
`define CA_WIDTH_BIT    7
`define CB_CS_LSB       0
`define CB_NC_BIT       4
`define CB_SRST_BIT     7
`define FL_OVF_BIT      0
`define FL_CMPA_BIT     1
`define FL_CMPB_BIT     2
`define FL_CAP_BIT      3

// ----------------------------------------------------------------------
// values and counts
// ----------------------------------------------------------------------
`define RESET_BYTE      8'h00
`define MAX8            8'hFF
`define MAX16           16'hFFFF
`define NC_SAMPLES      4
`define CS_EXT_FALL     3'h6
`define CS_EXT_RISE     3'h7

`endif

// >>> src/timer_pkg.sv
// types shared by the timer block
package timer_pkg;

  typedef enum logic [2:0] {
    MODE_NORMAL8,
    MODE_CTC8,
    MODE_NORMAL16,
    MODE_CAPTURE8,
    MODE_CAPTURE16
  } mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic overflow;
    logic compare_a;
    logic compare_b;
    logic capture;
  } irq_req_t;

endpackage

// >>> src/timer_modes_input_capture.sv
// 8/16-bit timer with normal, clear-on-match and input capture modes
//
// Behaviour
// - mode from capture enable, width and waveform bits; five modes, each with its top
// - normal 8-bit: low byte counts each timer tick, wraps 0xFF to 0x00
// - 8-bit modes set overflow flag in the tick the count increments from max to zero
// - counting only sets overflow flag; taking the interrupt clears it
// - clear-on-match: counter cleared to zero when equal to compare register a
// - compare writes act at once; below-count value means run through 0xFF first
// - clear-on-match still sets overflow flag on the 0xFF to 0x00 step when compare register a is not 0xFF
// - clear-on-match raises compare flag a on each reach of top
// - 16-bit: counter runs to 0xFFFF, wraps to zero, sets overflow flag then
// - compare register a is the 8-bit capture register; b stays a comparator
// - 16-bit capture: b holds capture high byte, no compare unit works
// - matching edge on selected capture input copies counter into capture register
// - capture flag set in the same clock as the copy
// - capture flag requests interrupt when enabled; cleared by ack or writing one
// - capture source is the pin, or comparator output when selected
// - capture inputs use the same synchroniser and edge detector as the count pin
// - noise canceler changes output only after four equal samples
// - enabling the noise canceler adds four clocks of capture delay
// - noise canceler samples on the system clock, not the prescaled one
// - each new capture overwrites the capture register, read or not
// - pin is sampled whatever its direction, so port toggles capture too
// - a processor counter write beats any simultaneous clear or increment
// - clock select zero stops counting; counter stays readable and writable
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "timer_params.svh"

module timer_modes_input_capture
  import timer_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire timer_pkg::reg_req_t req,
  output var  logic [7:0]         rdata,
  input  wire logic               timer_tick,
  input  wire logic               external_count_pin,
  input  wire logic               capture_input_pin,
  input  wire logic               comparator_output,
  input  wire timer_pkg::irq_req_t irq_ack,
  output var  timer_pkg::irq_req_t irq_req
);
  import timer_pkg::*;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0]  timer_control_a;
  logic [7:0]  timer_control_b;
  logic [15:0] counter_value;
  logic [7:0]  compare_reg_a;
  logic [7:0]  compare_reg_b;
  logic        overflow_flag;
  logic        compare_flag_a;
  logic        compare_flag_b;
  logic        capture_flag;
  logic [3:0]  irq_enable;
  mode_t       mode;

  logic counter_width_select;
  logic capture_enable;
  logic waveform_mode_select;
  logic capture_rising;
  logic comparator_capture_select;
  logic noise_canceler_enable;
  logic [2:0] clock_source_field;
  logic capture_irq_enable;

  assign waveform_mode_select      = timer_control_a[`CA_WAVE_BIT];
  assign capture_rising            = timer_control_a[`CA_EDGE_BIT];
  assign comparator_capture_select = timer_control_a[`CA_ACIC_BIT];
  assign capture_enable            = timer_control_a[`CA_CAPEN_BIT];
  assign counter_width_select      = timer_control_a[`CA_WIDTH_BIT];
  assign clock_source_field        = timer_control_b[`CB_CS_LSB +: 3];
  assign noise_canceler_enable     = timer_control_b[`CB_NC_BIT];
  assign capture_irq_enable        = irq_enable[`FL_CAP_BIT];

  logic wr_a;
  logic wr_b;
  logic wr_lo;
  logic wr_hi;
  logic wr_ca;
  logic wr_cb;
  logic wr_fl;
  logic wr_ie;
  logic soft_reset;

  assign wr_a  = req.wr && req.addr == `REG_CTRL_A;
  assign wr_b  = req.wr && req.addr == `REG_CTRL_B;
  assign wr_lo = req.wr && req.addr == `REG_CNT_LO;
  assign wr_hi = req.wr && req.addr == `REG_CNT_HI;
  assign wr_ca = req.wr && req.addr == `REG_CMP_A;
  assign wr_cb = req.wr && req.addr == `REG_CMP_B;
  assign wr_fl = req.wr && req.addr == `REG_FLAGS;
  assign wr_ie = req.wr && req.addr == `REG_IRQ_EN;
  // self-clearing: writing the soft reset bit pulses a synchronous clear
  assign soft_reset = wr_b && req.wdata[`CB_SRST_BIT];

  // ----------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    if (capture_enable)
      mode = counter_width_select ? MODE_CAPTURE16 : MODE_CAPTURE8;
    else if (counter_width_select)
      mode = MODE_NORMAL16;
    else
      mode = waveform_mode_select ? MODE_CTC8 : MODE_NORMAL8;
  end

  logic wide;
  assign wide = (mode == MODE_NORMAL16) || (mode == MODE_CAPTURE16);

  // ----------------------------------------------------------------------
  // input sampling: one synchroniser per input; edge paths for the count pin and the selected capture level
  // ----------------------------------------------------------------------
  // index 0 count pin, 1 capture pin, 2 comparator
  logic [2:0] raw_in;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] last;
  assign raw_in = {comparator_output, capture_input_pin, external_count_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end
        else
        begin
          // the pin is sampled whatever its port direction
          sync1[gi] <= raw_in[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // capture source select and noise canceler
  // ----------------------------------------------------------------------
  logic       cap_src;
  logic [2:0] nc_hist;
  logic       nc_out;
  logic       cap_level;

  assign cap_src = comparator_capture_select ? sync2[2] : sync2[1];

  always_ff @(posedge clk or negedge rstn) // system clock, never the tick
  begin
    if (!rstn)
    begin
      nc_hist <= 3'h0;
      nc_out  <= 1'b0;
    end
    else
    begin
      nc_hist <= {nc_hist[1:0], cap_src};
      // the current sample counts as the fourth, so the delay is four clocks, not five
      // four equal samples needed to move the output
      if ({nc_hist, cap_src} == {`NC_SAMPLES{1'b1}})
        nc_out <= 1'b1;
      else if ({nc_hist, cap_src} == 4'h0)
        nc_out <= 1'b0;
    end
  end

  assign cap_level = noise_canceler_enable ? nc_out : cap_src;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      last <= 3'h0;
    else
      last <= {cap_level, 1'b0, sync2[0]};
  end

  logic cap_event;
  logic ext_edge;
  // one edge detector shared in form by both paths
  assign cap_event = capture_rising ? (cap_level && !last[2])
                                    : (!cap_level && last[2]);
  assign ext_edge  = (clock_source_field == `CS_EXT_RISE) ? (sync2[0] && !last[0]) :
                     (clock_source_field == `CS_EXT_FALL) ? (!sync2[0] && last[0]) : 1'b0;

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  logic        count_en;
  logic        at_max;
  logic        ctc_match;
  logic [15:0] next_count;

  // clock select zero stops the count; register port still works
  assign count_en  = (clock_source_field == 3'h0) ? 1'b0 :
                     (clock_source_field[2:1] == 2'b11) ? ext_edge : timer_tick;
  assign at_max    = wide ? (counter_value == `MAX16) : (counter_value[7:0] == `MAX8);
  assign ctc_match = (mode == MODE_CTC8) && (counter_value[7:0] == compare_reg_a);

  always_comb
  begin
    next_count = counter_value;
    if (wr_lo) // processor write wins over clear and count
      next_count = {counter_value[15:8], req.wdata};
    else if (wr_hi)
      next_count = {req.wdata, counter_value[7:0]};
    else if (count_en)
    begin
      if (ctc_match) // match clears; a top below the count runs through max
        next_count = 16'h0000;
      else if (wide)
        next_count = counter_value + 16'h0001;
      else // 8-bit wrap
        next_count = {8'h00, counter_value[7:0] + 8'h01};
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      counter_value <= 16'h0000;
    else if (soft_reset)
      counter_value <= 16'h0000;
    else
      counter_value <= next_count;
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      timer_control_a <= `RESET_BYTE;
      timer_control_b <= `RESET_BYTE;
      irq_enable      <= 4'h0;
    end
    else if (soft_reset)
    begin
      timer_control_a <= `RESET_BYTE;
      timer_control_b <= `RESET_BYTE;
      irq_enable      <= 4'h0;
    end
    else
    begin
      if (wr_a)
        timer_control_a <= req.wdata;
      if (wr_b)
        timer_control_b <= {1'b0, req.wdata[6:0]};
      if (wr_ie)
        irq_enable <= req.wdata[3:0];
    end
  end

  // ----------------------------------------------------------------------
  // compare / capture registers
  // ----------------------------------------------------------------------
  logic capture_now;
  assign capture_now = capture_enable && cap_event;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      compare_reg_a <= `RESET_BYTE;
      compare_reg_b <= `RESET_BYTE;
    end
    else if (soft_reset)
    begin
      compare_reg_a <= `RESET_BYTE;
      compare_reg_b <= `RESET_BYTE;
    end
    else
    begin
      // capture overwrites unread values; it beats a same-cycle write
      if (capture_now) // a is the capture register
        compare_reg_a <= counter_value[7:0];
      else if (wr_ca) // no double buffering
        compare_reg_a <= req.wdata;
      if (capture_now && mode == MODE_CAPTURE16) // high byte in b
        compare_reg_b <= counter_value[15:8];
      else if (wr_cb)
        compare_reg_b <= req.wdata;
    end
  end

  // ----------------------------------------------------------------------
  // flags: hardware set wins over clear
  // ----------------------------------------------------------------------
  logic set_ovf;
  logic set_cmpa;
  logic set_cmpb;
  logic cmp_allowed;

  assign set_ovf  = count_en && !wr_lo && !wr_hi && at_max && !ctc_match;
  assign cmp_allowed = (mode != MODE_CAPTURE16);
  assign set_cmpa = count_en && cmp_allowed && !capture_enable &&
                    (wide ? counter_value == {compare_reg_b, compare_reg_a}
                          : counter_value[7:0] == compare_reg_a);
  assign set_cmpb = count_en && cmp_allowed && !wide &&
                    counter_value[7:0] == compare_reg_b;

  logic [3:0] flag_set;
  logic [3:0] flag_q;
  assign flag_set = {capture_now, set_cmpb, set_cmpa, set_ovf};
  assign flag_q   = {capture_flag, compare_flag_b, compare_flag_a, overflow_flag};

  logic [3:0] flag_clr;
  assign flag_clr = ({4{wr_fl}} & req.wdata[3:0]) | {irq_ack.capture, irq_ack.compare_b,
                    irq_ack.compare_a, irq_ack.overflow};

  logic [3:0] next_flags;
  assign next_flags = flag_set | (flag_q & ~flag_clr);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      {capture_flag, compare_flag_b, compare_flag_a, overflow_flag} <= 4'h0;
    else if (soft_reset)
      {capture_flag, compare_flag_b, compare_flag_a, overflow_flag} <= 4'h0;
    else
      {capture_flag, compare_flag_b, compare_flag_a, overflow_flag} <= next_flags;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_req <= '0;
    else
    begin
      irq_req.overflow  <= next_flags[0] && irq_enable[0] && !soft_reset;
      irq_req.compare_a <= next_flags[1] && irq_enable[1] && !soft_reset;
      irq_req.compare_b <= next_flags[2] && irq_enable[2] && !soft_reset;
      irq_req.capture   <= next_flags[3] && capture_irq_enable && !soft_reset;
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= 8'h00;
    else if (req.rd)
    begin
      unique case (req.addr)
        `REG_CTRL_A: rdata <= timer_control_a;
        `REG_CTRL_B: rdata <= timer_control_b;
        `REG_CNT_LO: rdata <= counter_value[7:0];
        `REG_CNT_HI: rdata <= counter_value[15:8];
        `REG_CMP_A:  rdata <= compare_reg_a;
        `REG_CMP_B:  rdata <= compare_reg_b;
        `REG_FLAGS:  rdata <= {4'h0, flag_q};
        `REG_IRQ_EN: rdata <= {4'h0, irq_enable};
        default:     rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_ovf_wrap8: assert property (@(posedge clk) disable iff (!rstn)
    (!wide && count_en && !wr_lo && !wr_hi && !soft_reset && at_max && !ctc_match)
      |=> (overflow_flag && counter_value[7:0] == 8'h00))
    else $error("overflow flag not set on 8-bit wrap");

  chk_ovf_sticky: assert property (@(posedge clk) disable iff (!rstn)
    (overflow_flag && !irq_ack.overflow && !(wr_fl && req.wdata[0]) && !soft_reset)
      |=> overflow_flag)
    else $error("overflow flag cleared by counting");

  chk_ctc_clear: assert property (@(posedge clk) disable iff (!rstn)
    (ctc_match && count_en && !wr_lo && !wr_hi && !soft_reset) |=> counter_value == 16'h0000)
    else $error("counter not cleared on match");

  chk_ctc_flag: assert property (@(posedge clk) disable iff (!rstn)
    (ctc_match && count_en && !soft_reset) |=> compare_flag_a)
    else $error("compare flag a missing at top");

  chk_wrap16: assert property (@(posedge clk) disable iff (!rstn)
    (wide && count_en && !wr_lo && !wr_hi && !soft_reset && counter_value == `MAX16)
      |=> (counter_value == 16'h0000 && overflow_flag))
    else $error("16-bit wrap wrong");

  chk_cap_copy: assert property (@(posedge clk) disable iff (!rstn)
    (capture_now && !soft_reset) |=> (compare_reg_a == $past(counter_value[7:0]) && capture_flag))
    else $error("capture value or flag wrong");

  chk_cpu_prio: assert property (@(posedge clk) disable iff (!rstn)
    (wr_lo && !soft_reset) |=> counter_value[7:0] == $past(req.wdata))
    else $error("counter write lost");

  chk_stopped: assert property (@(posedge clk) disable iff (!rstn)
    (clock_source_field == 3'h0 && !req.wr) |=> $stable(counter_value))
    else $error("counter moved while stopped");

  chk_soft_reset: assert property (@(posedge clk) disable iff (!rstn)
    soft_reset |=> (counter_value == 16'h0000 && timer_control_a == 8'h00 && flag_q == 4'h0))
    else $error("soft reset incomplete");

endmodule
`default_nettype wire

// >>> sim/event_source.sv
// model of the external event source that feeds both capture inputs
`timescale 1ns/100ps
`default_nettype none

module event_source
(
  input  wire logic clk,
  output var  logic capture_input_pin,
  output var  logic comparator_output
);
  initial
  begin
    capture_input_pin = 1'b0;
    comparator_output = 1'b0;
  end

  // ----------------------------------------------------------------
  // level changes
  // ----------------------------------------------------------------
  // both lines are driven levels, never released, so no float handling is needed;
  // a change lands just after an edge and is held for hold further edges
  task automatic drive(input logic sel, input logic level, input int hold);
    @(posedge clk);
    if (sel)
      comparator_output <= level;
    else
      capture_input_pin <= level;
    repeat (hold) @(posedge clk);
  endtask
endmodule

`default_nettype wire

// >>> sim/timer_modes_input_capture_test.sv
// self-checking bench for the timer with input capture
`timescale 1ns/100ps
`default_nettype none
`include "timer_params.svh"

`define CHECK(what, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("wrong value %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module timer_modes_input_capture_test;
  import timer_pkg::*;

  typedef struct {
    string      what;
    logic [7:0] value;
  } note_t;

  logic       clk;
  logic       rstn;
  reg_req_t   req;
  logic [7:0] rdata;
  logic       timer_tick;
  logic       ext_pin;
  logic       capture_input_pin;
  logic       comparator_output;
  irq_req_t   irq_ack;
  irq_req_t   irq_req;
  logic       rd_seen;
  note_t      notes[$];
  note_t      note;
  int         fails;
  int         tests_run;
  int         lat_plain;
  int         lat_filt;
  logic [7:0] rnd;

  always #2.5 clk = ~clk;

  timer_modes_input_capture u_timer_modes_input_capture (
    .clk(clk), .rstn(rstn), .req(req), .rdata(rdata), .timer_tick(timer_tick),
    .external_count_pin(ext_pin), .capture_input_pin(capture_input_pin),
    .comparator_output(comparator_output), .irq_ack(irq_ack), .irq_req(irq_req));

  event_source u_event_source (
    .clk(clk), .capture_input_pin(capture_input_pin),
    .comparator_output(comparator_output));

  // ----------------------------------------------------------------
  // read data watcher: read data stand only in the cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge clk) rd_seen <= req.rd;

  always @(negedge clk)
    if (rd_seen === 1'b1 && notes.size() > 0)
    begin
      note = notes.pop_front();
      `CHECK(note.what, note.value, rdata)
    end

  // ----------------------------------------------------------------
  // bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    notes.push_back('{what, exp});
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      timer_tick <= 1'b1;
      @(posedge clk);
      timer_tick <= 1'b0;
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic ack(input irq_req_t m);
    @(posedge clk);
    irq_ack <= m;
    @(posedge clk);
    irq_ack <= '0;
  endtask

  task automatic all_zero();
    for (int a = 0; a < 9; a++)
      rd(a[3:0], 8'h00, "cleared register");
  endtask

  // pin low and flag clear first, then count falling edges until the request shows
  task automatic latency(input logic nc, output int n);
    wr(`REG_CTRL_B, nc ? 8'h10 : 8'h00);
    u_event_source.drive(1'b0, 1'b0, 12);
    wr(`REG_FLAGS, 8'h08);
    u_event_source.drive(1'b0, 1'b1, 0);
    n = 0;
    while (irq_req.capture !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic test_done();
    $display("counts: %0d compared, %0d wrong", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog: the tests need some 470 cycles
  // ----------------------------------------------------------------
  initial
  begin
    #200000;
    fails++;
    test_done();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    req = '0;
    timer_tick = 1'b0;
    ext_pin = 1'b0;
    irq_ack = '0;
    rd_seen = 1'b0;
    fails = 0;
    tests_run = 0;
    void'($urandom(42));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    all_zero();
    $display("test done: reset values");
    // compare values away from every count used below, so no stray compare flag
    wr(`REG_CMP_A, 8'h55);
    wr(`REG_CMP_B, 8'h55);
    wr(`REG_CNT_LO, 8'hFE);
    tick(3);
    rd(`REG_CNT_LO, 8'hFE, "stopped count");
    wr(`REG_CTRL_B, 8'h01);
    tick(1);
    rd(`REG_FLAGS, 8'h00, "flags at max");
    tick(1);
    rd(`REG_CNT_LO, 8'h00, "wrapped count");
    rd(`REG_FLAGS, 8'h01, "overflow flag");
    @(posedge clk);
    timer_tick <= 1'b1;
    req <= '{addr: `REG_CNT_LO, wdata: 8'h10, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    timer_tick <= 1'b0;
    req.wr <= 1'b0;
    rd(`REG_CNT_LO, 8'h10, "write against tick");
    rd(`REG_FLAGS, 8'h01, "overflow kept");
    ack(irq_req_t'(4'h8));
    rd(`REG_FLAGS, 8'h00, "overflow acked");
    $display("test done: normal 8-bit");
    wr(`REG_CTRL_A, 8'h01);
    wr(`REG_CMP_A, 8'h03);
    wr(`REG_CNT_LO, 8'h00);
    tick(3);
    rd(`REG_FLAGS, 8'h00, "before top");
    tick(1);
    rd(`REG_CNT_LO, 8'h00, "cleared at top");
    rd(`REG_FLAGS, 8'h02, "compare a at top");
    wr(`REG_FLAGS, 8'h02);
    tick(4);
    rd(`REG_FLAGS, 8'h02, "next period");
    wr(`REG_FLAGS, 8'h0F);
    wr(`REG_CNT_LO, 8'hFE);
    wr(`REG_CMP_A, 8'h02);
    tick(2);
    rd(`REG_FLAGS, 8'h01, "overflow in clear mode");
    tick(2);
    rd(`REG_CNT_LO, 8'h02, "run past max");
    tick(1);
    rd(`REG_FLAGS, 8'h03, "late match");
    $display("test done: clear on match");
    wr(`REG_CTRL_A, 8'h80);
    wr(`REG_FLAGS, 8'h0F);
    wr(`REG_CNT_HI, 8'hFF);
    wr(`REG_CNT_LO, 8'hFE);
    tick(1);
    rd(`REG_FLAGS, 8'h00, "flags at 16-bit max");
    tick(1);
    rd(`REG_CNT_HI, 8'h00, "16-bit wrap");
    rd(`REG_FLAGS, 8'h01, "16-bit overflow");
    $display("test done: 16-bit");
    wr(`REG_CTRL_B, 8'h00);
    wr(`REG_CTRL_A, 8'h48);
    wr(`REG_IRQ_EN, 8'h08);
    wr(`REG_FLAGS, 8'h0F);
    wr(`REG_CMP_B, 8'h77);
    for (int i = 0; i < 2; i++)
    begin
      rnd = 8'($urandom);
      wr(`REG_CNT_LO, rnd);
      u_event_source.drive(1'b0, 1'b1, 8);
      wr(`REG_CNT_LO, ~rnd);
      u_event_source.drive(1'b0, 1'b0, 8);
    end
    rd(`REG_CMP_A, rnd, "latest rising capture");
    rd(`REG_CMP_B, 8'h77, "compare b kept");
    rd(`REG_FLAGS, 8'h08, "capture flag");
    `CHECK("capture request", 1'b1, irq_req.capture)
    wr(`REG_IRQ_EN, 8'h00);
    idle(2);
    `CHECK("masked request", 1'b0, irq_req.capture)
    wr(`REG_IRQ_EN, 8'h08);
    ack(irq_req_t'(4'h1));
    rd(`REG_FLAGS, 8'h00, "capture acked");
    wr(`REG_CTRL_A, 8'h40);
    wr(`REG_CNT_LO, 8'h3C);
    u_event_source.drive(1'b0, 1'b1, 8);
    wr(`REG_CNT_LO, 8'hC3);
    u_event_source.drive(1'b0, 1'b0, 8);
    rd(`REG_CMP_A, 8'hC3, "falling capture");
    wr(`REG_CTRL_A, 8'h48);
    wr(`REG_FLAGS, 8'h08);
    wr(`REG_CNT_LO, 8'h5A);
    u_event_source.drive(1'b0, 1'b1, 8);
    rd(`REG_CMP_A, 8'h5A, "inverted edge capture");
    wr(`REG_CTRL_A, 8'h40);
    u_event_source.drive(1'b0, 1'b0, 8);
    $display("test done: 8-bit capture");
    wr(`REG_CTRL_A, 8'h58);
    idle(8);
    wr(`REG_FLAGS, 8'h08);
    wr(`REG_CNT_LO, 8'h21);
    u_event_source.drive(1'b0, 1'b1, 8);
    rd(`REG_FLAGS, 8'h00, "pin not selected");
    wr(`REG_CNT_LO, 8'h42);
    u_event_source.drive(1'b1, 1'b1, 8);
    rd(`REG_CMP_A, 8'h42, "comparator capture");
    u_event_source.drive(1'b1, 1'b0, 8);
    $display("test done: capture source");
    wr(`REG_CTRL_A, 8'hC8);
    u_event_source.drive(1'b0, 1'b0, 8);
    wr(`REG_FLAGS, 8'h08);
    wr(`REG_CNT_HI, 8'h12);
    wr(`REG_CNT_LO, 8'h34);
    u_event_source.drive(1'b0, 1'b1, 8);
    rd(`REG_CMP_A, 8'h34, "16-bit capture low");
    rd(`REG_CMP_B, 8'h12, "16-bit capture high");
    $display("test done: 16-bit capture");
    wr(`REG_CTRL_A, 8'h48);
    wr(`REG_CTRL_B, 8'h10);
    u_event_source.drive(1'b0, 1'b0, 12);
    wr(`REG_FLAGS, 8'h08);
    u_event_source.drive(1'b0, 1'b1, 2);
    u_event_source.drive(1'b0, 1'b0, 12);
    rd(`REG_FLAGS, 8'h00, "short pulse filtered");
    latency(1'b0, lat_plain);
    latency(1'b1, lat_filt);
    `CHECK("filter delay", 4, lat_filt - lat_plain)
    $display("test done: noise canceler");
    wr(`REG_CTRL_B, 8'h07);
    wr(`REG_CNT_LO, 8'h00);
    repeat (2)
    begin
      @(posedge clk);
      ext_pin <= 1'b1;
      idle(3);
      @(posedge clk);
      ext_pin <= 1'b0;
      idle(3);
    end
    rd(`REG_CNT_LO, 8'h02, "external rising count");
    $display("test done: external count");
    wr(`REG_CTRL_B, 8'h80);
    all_zero();
    $display("test done: soft reset");
    idle(4);
    test_done();
  end
endmodule

`default_nettype wire
